// [rtl/lsa_regs.svh]
/*
 * Register offsets, field positions, reset values and fault codes of the
 * load/store alignment unit.
 * Assumes a 12-bit APB byte address and 32-bit data.
 */
`ifndef LSA_REGS_SVH
`define LSA_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define LSA_SYSCTRL_OFS 12'h000
`define LSA_STATUS_OFS 12'h004
`define LSA_FSTAT_OFS 12'h008
`define LSA_FADDR_OFS 12'h00C

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define LSA_UNAL_BIT 22
`define LSA_CHECK_BIT 1
`define LSA_ENDIAN_BIT 0
`define LSA_SYSCTRL_RST 32'h0000_0000
`define LSA_STATUS_RST 32'h0000_0000

// ****************************************************************
// Fault status codes
// ****************************************************************
`define LSA_FSC_NONE 4'h0
`define LSA_FSC_ALIGN 4'h1
`define LSA_FSC_EXT 4'h8

`endif

// [rtl/lsa_pkg.sv]
/*
 * Types of the load/store alignment unit: access sizes and kinds, the
 * request, memory and response carriers and the controller states.
 * Assumes the constants of lsa_regs.svh are included where needed.
 */
package lsa_pkg;

  typedef enum logic [1:0] {
    LSA_BYTE = 2'h0,
    LSA_HALF = 2'h1,
    LSA_WORD = 2'h2,
    LSA_DOUBLE = 2'h3
  } lsa_size_type;

  typedef enum logic [2:0] {
    LSA_SINGLE = 3'h0,
    LSA_MULTIPLE = 3'h1,
    LSA_SWAP = 3'h2,
    LSA_COPROC = 3'h3,
    LSA_FETCH = 3'h4
  } lsa_kind_type;

  // Count holds the number of words less one for multiple accesses.
  typedef struct packed {
    logic [31:0] addr;
    logic [63:0] wdata;
    lsa_size_type size;
    lsa_kind_type kind;
    logic load;
    logic signed_ld;
    logic pc_dest;
    logic compact_isa;
    logic strong_mem;
    logic [3:0] count;
  } lsa_req_type;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [31:0] wdata;
    logic [3:0] be;
  } lsa_mem_type;

  typedef struct packed {
    logic [31:0] data;
    logic abort;
    logic [3:0] fsc;
    logic last;
  } lsa_resp_type;

  typedef enum logic [4:0] {
    LSA_IDLE = 5'b00001,
    LSA_EVAL = 5'b00010,
    LSA_ISSUE = 5'b00100,
    LSA_WAIT = 5'b01000,
    LSA_DONE = 5'b10000
  } lsa_state_type;

endpackage

// [rtl/lsa_align_unit.sv]
/*
 * Load/store alignment unit: alignment fault detection, memory address
 * formation, splitting of unaligned transfers and load/store data
 * formatting, with its control bits reached over APB.
 * Assumes the core and the memory port run on ref_clk, one request at a
 * time, and that the memory port answers each beat exactly once.
 */
// Local design decisions: the APB register port and the placing of the registers.
// Summary of operation
// - Instruction fetches must be naturally aligned.
// - Unaligned enable bit 22, check bit 1.
// - Two control bits select the handling model.
// - Legacy checking faults misaligned half, word, double.
// - Alignment fault aborts with alignment status code.
// - Legacy unchecked: addresses truncated by access size.
// - Legacy word load rotates right by offset.
// - Legacy multiples and word stores never rotate.
// - Legacy doublewords treated as 64-bit aligned.
// - Legacy misaligned halfword results are undefined.
// - Unaligned mode faults misaligned multi, double, swap.
// - Strict check faults misaligned half and word.
// - Unaligned transfers split into aligned beats.
// - Split transfers are not locked or atomic.
// - Unaligned load into program counter faults.
// - Either half may abort; report restartably.
// - Unaligned access to strong/device memory faults.
// - Fault detection lives inside address generation.
// - Unsigned byte load zero-extends to 32 bits.
// - Signed byte load sign-extends from bit 7.
// - Byte store writes low eight bits.
// - Address names LSB little, MSB big-endian.
// - Unaligned enable bit resets to zero.
// - Endian flag clears on reset, exception entry.
// - Unsigned halfword load zero-extends, low byte first.
`timescale 1ns/10ps
`default_nettype none
`include "lsa_regs.svh"

module lsa_align_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core request
  input wire logic core_req_valid,
  input wire lsa_pkg::lsa_req_type core_req,
  output logic core_req_ready,
  input wire logic exception_entry,
  input wire logic [31:0] stream_wdata,
  output logic [4:0] core_beat,
  // Core response
  output logic core_resp_valid,
  output lsa_pkg::lsa_resp_type core_resp,
  // Memory port
  output logic mem_req_valid,
  output lsa_pkg::lsa_mem_type mem_req,
  input wire logic mem_ready,
  input wire logic mem_resp_valid,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_abort
);
  import lsa_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [31:0] swap_word(input logic [31:0] w);
    swap_word = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  function automatic logic [15:0] swap_half(input logic [15:0] h);
    swap_half = {h[7:0], h[15:8]};
  endfunction

  // Decision is made here from the latched request and control bits only,
  // so no external memory management unit is involved.
  function automatic logic align_fault(input lsa_req_type r,
                                       input logic unal,
                                       input logic check);
    logic mis_h;
    logic mis_w;
    logic mis_d;
    logic natural;
    mis_h = r.addr[0];
    mis_w = |r.addr[1:0];
    mis_d = |r.addr[2:0];
    natural = 1'b0;
    unique case (r.size)
      LSA_BYTE: natural = 1'b0;
      LSA_HALF: natural = mis_h;
      LSA_WORD: natural = mis_w;
      LSA_DOUBLE: natural = unal ? mis_w : mis_d;
    endcase
    if (r.kind == LSA_FETCH) begin
      align_fault = r.compact_isa ? mis_h : mis_w;
    end else if (!unal) begin
      align_fault = check & natural;
    end else if (r.kind != LSA_SINGLE || r.size == LSA_DOUBLE) begin
      align_fault = mis_w;
    end else begin
      // Strict check, PC loads and ordered memory refuse splitting.
      align_fault = natural & (check | (r.load & r.pc_dest) |
                    r.strong_mem);
    end
  endfunction

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic unal_en_q;
  logic check_en_q;
  logic big_end_q;
  logic [3:0] fstat_q;
  logic [31:0] faddr_q;
  logic apb_access;
  logic apb_hit;
  logic [31:0] sysctrl_rst;
  logic [31:0] status_rst;

  assign sysctrl_rst = `LSA_SYSCTRL_RST;
  assign status_rst = `LSA_STATUS_RST;
  assign apb_access = psel & penable & ~pready;
  assign apb_hit = (paddr == `LSA_SYSCTRL_OFS) ||
                   (paddr == `LSA_STATUS_OFS) ||
                   (paddr == `LSA_FSTAT_OFS) ||
                   (paddr == `LSA_FADDR_OFS);

  // One wait state: the access phase is answered on its second edge.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access & ~apb_hit;
      prdata <= 32'h0000_0000;
      if (apb_access && !pwrite) begin
        unique case (paddr)
          `LSA_SYSCTRL_OFS: begin
            prdata[`LSA_UNAL_BIT] <= unal_en_q;
            prdata[`LSA_CHECK_BIT] <= check_en_q;
          end
          `LSA_STATUS_OFS: prdata[`LSA_ENDIAN_BIT] <= big_end_q;
          `LSA_FSTAT_OFS: prdata[3:0] <= fstat_q;
          `LSA_FADDR_OFS: prdata <= faddr_q;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      unal_en_q <= sysctrl_rst[`LSA_UNAL_BIT];
      check_en_q <= sysctrl_rst[`LSA_CHECK_BIT];
    end else if (apb_access && pwrite &&
                 paddr == `LSA_SYSCTRL_OFS) begin
      unal_en_q <= pwdata[`LSA_UNAL_BIT];
      check_en_q <= pwdata[`LSA_CHECK_BIT];
    end
  end

  // Exception entry is a hardware event and wins over a software write.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      big_end_q <= status_rst[`LSA_ENDIAN_BIT];
    end else if (exception_entry) begin
      big_end_q <= 1'b0;
    end else if (apb_access && pwrite &&
                 paddr == `LSA_STATUS_OFS) begin
      big_end_q <= pwdata[`LSA_ENDIAN_BIT];
    end
  end

  // ****************************************************************
  // Access controller
  // ****************************************************************
  lsa_state_type state_q;
  lsa_req_type req_q;
  logic unal_q;
  logic check_q;
  logic big_q;
  logic [31:0] base_q;
  logic [1:0] lane_q;
  logic split_q;
  logic multi_q;
  logic [4:0] beats_q;
  logic [31:0] lo_q;
  logic [31:0] hi_q;
  logic fault_d;
  logic [31:0] base_d;
  logic split_d;
  logic [4:0] beats_d;
  logic [2:0] sum_d;
  logic last_beat;

  assign fault_d = align_fault(req_q, unal_q, check_q);
  assign last_beat = (core_beat == beats_q - 5'h01);

  // Address formation and beat plan from the latched request.
  always_comb begin
    base_d = req_q.addr;
    split_d = 1'b0;
    beats_d = 5'h01;
    sum_d = 3'h0;
    unique case (req_q.size)
      LSA_BYTE: base_d = req_q.addr;
      LSA_HALF: begin
        sum_d = {1'b0, req_q.addr[1:0]} + 3'h1;
        if (unal_q) begin
          split_d = sum_d[2];
        end else begin
          base_d = {req_q.addr[31:1], 1'b0};
        end
      end
      LSA_WORD: begin
        if (unal_q && req_q.kind == LSA_SINGLE) begin
          split_d = |req_q.addr[1:0];
        end else begin
          base_d = {req_q.addr[31:2], 2'b00};
        end
      end
      LSA_DOUBLE: begin
        base_d = {req_q.addr[31:3], 3'b000};
        beats_d = 5'h02;
      end
    endcase
    if (req_q.kind == LSA_MULTIPLE) begin
      beats_d = {1'b0, req_q.count} + 5'h01;
    end
    if (split_d) begin
      beats_d = 5'h02;
    end
  end

  // Byte enables and store data for a beat. A split store writes the
  // low lanes first and the spill into the next word second; the two
  // writes are separate, unlocked transactions, so another master may
  // see the halves apart.
  logic [31:0] st_fmt;
  logic [63:0] st_wide;
  logic [7:0] be_wide;
  logic [3:0] be_mask;
  logic [31:0] beat_wdata;
  logic [3:0] beat_be;
  logic [31:0] beat_addr;
  logic [4:0] next_beat;
  logic [1:0] lane_now;

  assign next_beat = core_beat + 5'h01;
  // The lanes are known in EVAL, so the first beat is whole when raised.
  assign lane_now = (state_q == LSA_EVAL) ? base_d[1:0] : lane_q;

  always_comb begin
    st_fmt = req_q.wdata[31:0];
    be_mask = 4'hF;
    unique case (req_q.size)
      LSA_BYTE: begin
        st_fmt = {24'h00_0000, req_q.wdata[7:0]};
        be_mask = 4'h1;
      end
      LSA_HALF: begin
        st_fmt = {16'h0000, big_q ? swap_half(req_q.wdata[15:0]) :
                  req_q.wdata[15:0]};
        be_mask = 4'h3;
      end
      default: begin
        st_fmt = big_q ? swap_word(req_q.wdata[31:0]) :
                 req_q.wdata[31:0];
        be_mask = 4'hF;
      end
    endcase
    st_wide = {32'h0000_0000, st_fmt} << {lane_now, 3'b000};
    be_wide = {4'h0, be_mask} << lane_now;
  end

  always_comb begin
    beat_addr = {base_q[31:2], 2'b00} + {25'h000_0000, next_beat, 2'b00};
    if (multi_q) begin
      beat_be = 4'hF;
      beat_wdata = (req_q.kind == LSA_MULTIPLE) ? stream_wdata :
                   req_q.wdata[63:32];
      if (big_q) begin
        beat_wdata = swap_word(beat_wdata);
      end
    end else begin
      beat_be = be_wide[7:4];
      beat_wdata = st_wide[63:32];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= LSA_IDLE;
      core_req_ready <= 1'b0;
      req_q <= '0;
      unal_q <= 1'b0;
      check_q <= 1'b0;
      big_q <= 1'b0;
      base_q <= 32'h0000_0000;
      lane_q <= 2'b00;
      split_q <= 1'b0;
      multi_q <= 1'b0;
      beats_q <= 5'h01;
      core_beat <= 5'h00;
      mem_req_valid <= 1'b0;
      mem_req <= '0;
    end else begin
      unique case (state_q)
        LSA_IDLE: begin
          core_req_ready <= 1'b1;
          if (core_req_valid && core_req_ready) begin
            core_req_ready <= 1'b0;
            req_q <= core_req;
            unal_q <= unal_en_q;
            check_q <= check_en_q;
            big_q <= big_end_q;
            core_beat <= 5'h00;
            state_q <= LSA_EVAL;
          end
        end
        LSA_EVAL: begin
          base_q <= base_d;
          lane_q <= base_d[1:0];
          split_q <= split_d;
          multi_q <= (req_q.kind == LSA_MULTIPLE) ||
                     (req_q.size == LSA_DOUBLE);
          beats_q <= beats_d;
          if (fault_d) begin
            state_q <= LSA_DONE;
          end else begin
            // The first beat uses the truncated address, so the
            // bus lanes follow the low bits given by the size.
            mem_req_valid <= 1'b1;
            mem_req.addr <= split_d ? {base_d[31:2], 2'b00} : base_d;
            mem_req.write <= ~req_q.load;
            mem_req.wdata <= st_wide[31:0];
            mem_req.be <= req_q.load ? 4'hF : be_wide[3:0];
            state_q <= LSA_ISSUE;
          end
        end
        LSA_ISSUE: begin
          // Address, data and lanes stand unchanged until accepted.
          if (mem_ready && mem_req_valid) begin
            mem_req_valid <= 1'b0;
            state_q <= LSA_WAIT;
          end
        end
        LSA_WAIT: begin
          if (mem_resp_valid) begin
            if (mem_abort || last_beat) begin
              state_q <= LSA_DONE;
            end else begin
              core_beat <= next_beat;
              mem_req_valid <= 1'b1;
              mem_req.addr <= beat_addr;
              mem_req.wdata <= beat_wdata;
              mem_req.be <= mem_req.write ? beat_be : 4'hF;
              state_q <= LSA_ISSUE;
            end
          end
        end
        LSA_DONE: begin
          core_req_ready <= 1'b1;
          state_q <= LSA_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Load data capture and formatting
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lo_q <= 32'h0000_0000;
      hi_q <= 32'h0000_0000;
    end else if (state_q == LSA_WAIT && mem_resp_valid) begin
      if (core_beat == 5'h00) begin
        lo_q <= mem_rdata;
      end else begin
        hi_q <= mem_rdata;
      end
    end
  end

  logic [63:0] ld_wide;
  logic [31:0] ld_raw;
  logic [63:0] ld_rot;
  logic [15:0] ld_half;
  logic [31:0] ld_word;
  logic [31:0] ld_out;
  logic [31:0] lo_now;
  logic [31:0] hi_now;

  // The last beat's data is used straight from the port to save a cycle.
  always_comb begin
    lo_now = (core_beat == 5'h00) ? mem_rdata : lo_q;
    hi_now = (core_beat == 5'h00) ? hi_q : mem_rdata;
    ld_wide = {hi_now, lo_now} >> {lane_q, 3'b000};
    ld_rot = {lo_now, lo_now} >> {req_q.addr[1:0], 3'b000};
    // Legacy misaligned halfword and compact-set word loads return
    // whatever the truncated lanes hold; no value is promised.
    ld_raw = ld_wide[31:0];
    if (!unal_q && req_q.size == LSA_WORD && !req_q.compact_isa) begin
      ld_raw = ld_rot[31:0];
    end
    ld_half = big_q ? swap_half(ld_raw[15:0]) : ld_raw[15:0];
    ld_word = big_q ? swap_word(ld_raw) : ld_raw;
    unique case (req_q.size)
      LSA_BYTE: begin
        ld_out = req_q.signed_ld ? {{24{ld_raw[7]}}, ld_raw[7:0]} :
                 {24'h00_0000, ld_raw[7:0]};
      end
      LSA_HALF: begin
        ld_out = req_q.signed_ld ? {{16{ld_half[15]}}, ld_half} :
                 {16'h0000, ld_half};
      end
      default: ld_out = ld_word;
    endcase
    if (multi_q) begin
      ld_out = big_q ? swap_word(mem_rdata) : mem_rdata;
    end
  end

  // ****************************************************************
  // Core response and fault record
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      core_resp_valid <= 1'b0;
      core_resp <= '0;
    end else begin
      core_resp_valid <= 1'b0;
      core_resp.last <= 1'b0;
      if (state_q == LSA_EVAL && fault_d) begin
        core_resp_valid <= 1'b1;
        core_resp.data <= 32'h0000_0000;
        core_resp.abort <= 1'b1;
        core_resp.fsc <= `LSA_FSC_ALIGN;
        core_resp.last <= 1'b1;
      end else if (state_q == LSA_WAIT && mem_resp_valid) begin
        // Multi-word loads hand back each word; the rest answer once.
        if (mem_abort || last_beat || (multi_q && req_q.load)) begin
          core_resp_valid <= 1'b1;
          core_resp.data <= (req_q.load && !mem_abort) ? ld_out :
                            32'h0000_0000;
          core_resp.abort <= mem_abort;
          core_resp.fsc <= mem_abort ? `LSA_FSC_EXT : `LSA_FSC_NONE;
          core_resp.last <= mem_abort | last_beat;
        end
      end
    end
  end

  // The faulting beat address is kept so the handler can restart it.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fstat_q <= `LSA_FSC_NONE;
      faddr_q <= 32'h0000_0000;
    end else if (state_q == LSA_EVAL && fault_d) begin
      fstat_q <= `LSA_FSC_ALIGN;
      faddr_q <= req_q.addr;
    end else if (state_q == LSA_WAIT && mem_resp_valid && mem_abort) begin
      fstat_q <= `LSA_FSC_EXT;
      faddr_q <= mem_req.addr;
    end
  end

endmodule
`default_nettype wire

// [test/lsa_align_unit_sva.sv]
/* Port checker of the alignment unit.
   Assumes it is bound to lsa_align_unit from the bench top. */
`timescale 1ns/10ps
`default_nettype none
`include "lsa_regs.svh"
module lsa_align_unit_sva
  import lsa_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Core and memory
  input wire logic core_req_valid,
  input wire lsa_pkg::lsa_req_type core_req,
  input wire logic core_req_ready,
  input wire logic core_resp_valid,
  input wire lsa_pkg::lsa_resp_type core_resp,
  input wire logic mem_req_valid,
  input wire lsa_pkg::lsa_mem_type mem_req
);
  logic unal_q;
  logic chk_q;
  logic take;
  logic mis;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  assign take = core_req_valid && core_req_ready;
  assign mis = core_req.addr[1:0] != 2'h0;
  // Mirror of the control bits.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      unal_q <= 1'b0;
      chk_q <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == 12'h000) begin
      unal_q <= pwdata[`LSA_UNAL_BIT];
      chk_q <= pwdata[`LSA_CHECK_BIT];
    end
  end
  sequence flt;
    core_resp_valid && core_resp.abort && core_resp.last
    && core_resp.fsc == `LSA_FSC_ALIGN;
  endsequence
  AST_FETCH: assert property (
    take && core_req.kind == LSA_FETCH && !core_req.compact_isa && mis
    |-> ##2 flt) else $error("fetch");
  AST_LEGACY_HALF: assert property (
    take && !unal_q && chk_q && core_req.size == LSA_HALF
    && core_req.addr[0] |-> ##2 flt) else $error("half");
  AST_UNAL_MULTI: assert property (
    take && unal_q && core_req.kind == LSA_MULTIPLE && mis |-> ##2 flt)
    else $error("multi");
  AST_PC_LOAD: assert property (
    take && unal_q && core_req.load && core_req.pc_dest && mis
    && core_req.size == LSA_WORD |-> ##2 flt) else $error("pc");
  AST_STRONG: assert property (
    take && unal_q && core_req.strong_mem && mis
    && core_req.size == LSA_WORD |-> ##2 flt) else $error("strong");
  AST_NO_BEAT: assert property (
    core_resp_valid && core_resp.fsc == `LSA_FSC_ALIGN |-> !mem_req_valid
    && !$past(mem_req_valid) && !$past(mem_req_valid, 2))
    else $error("beat");
  AST_TRUNC: assert property (
    take && !unal_q && !chk_q && core_req.size == LSA_WORD
    && core_req.kind == LSA_SINGLE |-> ##2 mem_req_valid
    && mem_req.addr == {$past(core_req.addr[31:2], 2), 2'h0})
    else $error("trunc");
  AST_CODE: assert property (
    core_resp_valid && core_resp.abort |-> core_resp.last
    && core_resp.fsc inside {`LSA_FSC_ALIGN, `LSA_FSC_EXT})
    else $error("code");
endmodule
`default_nettype wire

// [test/lsa_mem_model.sv]
/* Memory partner: sixteen words, settable stall, injected abort.
   Assumes one beat outstanding at a time. */
`timescale 1ns/10ps
`default_nettype none
module lsa_mem_model
  import lsa_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Bench controls
  input wire logic [2:0] wait_n,
  input wire logic [31:0] abort_addr,
  // Memory port
  input wire logic mem_req_valid,
  input wire lsa_pkg::lsa_mem_type mem_req,
  output logic mem_ready,
  output logic mem_resp_valid,
  output logic [31:0] mem_rdata,
  output logic mem_abort
);
  logic [31:0] mem [16];
  lsa_mem_type req_q;
  logic busy_q;
  logic [2:0] cnt_q;
  // Word i holds bytes Ci, Di, Ei, Fi from the lowest address up.
  initial begin
    mem_rdata = 32'h5A5A_5A5A;
    for (int i = 0; i < 16; i++) begin
      mem[i] = {4'hF, 4'(i), 4'hE, 4'(i), 4'hD, 4'(i), 4'hC, 4'(i)};
    end
  end
  // Idle read data toggles so stale data never passes as a response.
  always @(posedge ref_clk) begin
    mem_ready <= 1'b0;
    mem_resp_valid <= 1'b0;
    mem_abort <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (reset) begin
      busy_q <= 1'b0;
      cnt_q <= 3'h0;
    end else if (busy_q || (mem_req_valid && !mem_ready)) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == wait_n) begin
        cnt_q <= 3'h0;
        busy_q <= !busy_q;
        mem_ready <= !busy_q;
        req_q <= mem_req;
        if (busy_q) begin
          mem_resp_valid <= 1'b1;
          mem_abort <= req_q.addr[31:2] == abort_addr[31:2];
          mem_rdata <= mem[req_q.addr[5:2]];
          for (int b = 0; b < 4; b++) begin
            if (req_q.write && req_q.be[b]) begin
              mem[req_q.addr[5:2]][8*b+:8] <= req_q.wdata[8*b+:8];
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// [test/test_lsa_align_unit.sv]
/* Self-checking bench of the alignment unit.
   Assumes the checker and memory model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "lsa_regs.svh"
module test_lsa_align_unit;
  import lsa_pkg::*;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, stream_wdata, mem_rdata, abort_addr, rd, d;
  logic [3:0] fs;
  logic core_req_valid, core_req_ready, exception_entry, core_resp_valid;
  logic mem_req_valid, mem_ready, mem_resp_valid, mem_abort;
  logic [4:0] core_beat;
  logic [2:0] wait_n;
  lsa_req_type core_req;
  lsa_resp_type core_resp;
  lsa_mem_type mem_req;
  int failures, n_checks, takes;
  lsa_align_unit i_dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .core_req_valid, .core_req,
    .core_req_ready, .exception_entry, .stream_wdata, .core_beat,
    .core_resp_valid, .core_resp, .mem_req_valid, .mem_req, .mem_ready,
    .mem_resp_valid, .mem_rdata, .mem_abort);
  lsa_mem_model i_mem (.ref_clk, .reset, .wait_n, .abort_addr,
    .mem_req_valid, .mem_req, .mem_ready, .mem_resp_valid, .mem_rdata,
    .mem_abort);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (mem_req_valid && mem_ready) takes++;
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic ctl(input logic u, input logic c);
    apb(1'b1, `LSA_SYSCTRL_OFS, (32'(u) << `LSA_UNAL_BIT) |
      (32'(c) << `LSA_CHECK_BIT));
  endtask
  function automatic lsa_req_type mk(input logic [31:0] a,
    input lsa_size_type s, input logic [1:0] ls = 2'h2,
    input lsa_kind_type k = LSA_SINGLE);
    mk = '0;
    mk.addr = a;
    mk.size = s;
    mk.kind = k;
    mk.load = ls[1];
    mk.signed_ld = ls[0];
    mk.wdata = 64'h1234_5678_ABCD_EF5A;
  endfunction
  task automatic run(input lsa_req_type r);
    core_req <= r;
    core_req_valid <= 1'b1;
    do @(posedge ref_clk); while (core_req_ready !== 1'b1);
    core_req_valid <= 1'b0;
    do @(posedge ref_clk);
    while (core_resp_valid !== 1'b1 || core_resp.last !== 1'b1);
    d = core_resp.data;
    fs = core_resp.fsc;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic ld(input string w, input lsa_req_type r,
    input logic [31:0] e);
    run(r);
    chk(w, d, e);
  endtask
  task automatic flt(input string w, input lsa_req_type r);
    int n;
    n = takes;
    run(r);
    chk(w, {28'h0, fs}, {28'h0, `LSA_FSC_ALIGN});
    chk("beats", 32'(takes - n), 32'h0);
  endtask
  task automatic t_regs;
    apb(1'b0, `LSA_SYSCTRL_OFS, 32'h0);
    chk("ctrl rst", rd, 32'h0);
    apb(1'b1, `LSA_STATUS_OFS, 32'h1);
    apb(1'b0, `LSA_STATUS_OFS, 32'h0);
    chk("stat set", rd, 32'h1);
    exception_entry <= 1'b1;
    @(posedge ref_clk);
    exception_entry <= 1'b0;
    apb(1'b0, `LSA_STATUS_OFS, 32'h0);
    chk("stat clr", rd, 32'h0);
    ctl(1'b1, 1'b1);
    apb(1'b0, `LSA_SYSCTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h0040_0002);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
  endtask
  task automatic t_legacy;
    lsa_req_type r;
    ctl(1'b0, 1'b0);
    ld("rot", mk(32'h5, LSA_WORD), 32'hC1F1_E1D1);
    ld("ub", mk(32'hB, LSA_BYTE), 32'h0000_00F2);
    ld("sb", mk(32'hB, LSA_BYTE, 2'h3), 32'hFFFF_FFF2);
    ld("uh", mk(32'hE, LSA_HALF), 32'h0000_F3E3);
    ld("dbl", mk(32'hC, LSA_DOUBLE), 32'hF3E3_D3C3);
    r = mk(32'h6, LSA_WORD, 2'h2, LSA_MULTIPLE);
    r.count = 4'h1;
    ld("mul", r, 32'hF2E2_D2C2);
    ld("sbst", mk(32'h22, LSA_BYTE, 2'h0), 32'h0);
    ld("sbrd", mk(32'h20, LSA_WORD), 32'hF85A_D8C8);
    ctl(1'b0, 1'b1);
    flt("half", mk(32'h3, LSA_HALF));
    flt("dbl", mk(32'h4, LSA_DOUBLE));
    r = mk(32'h1, LSA_HALF, 2'h2, LSA_FETCH);
    r.compact_isa = 1'b1;
    flt("fetch", r);
  endtask
  task automatic t_unal;
    lsa_req_type r;
    int n;
    ctl(1'b1, 1'b0);
    wait_n <= 3'h3;
    n = takes;
    ld("split", mk(32'h7, LSA_WORD), 32'hE2D2_C2F1);
    chk("split n", 32'(takes - n), 32'h2);
    wait_n <= 3'h0;
    flt("mul", mk(32'h6, LSA_WORD, 2'h2, LSA_MULTIPLE));
    flt("swp", mk(32'h6, LSA_WORD, 2'h2, LSA_SWAP));
    r = mk(32'h5, LSA_WORD);
    r.pc_dest = 1'b1;
    flt("pc", r);
    r.pc_dest = 1'b0;
    r.strong_mem = 1'b1;
    flt("strong", r);
    ctl(1'b1, 1'b1);
    flt("strict", mk(32'h1, LSA_HALF));
  endtask
  task automatic t_abort;
    ctl(1'b1, 1'b0);
    abort_addr <= 32'h30;
    run(mk(32'h2E, LSA_WORD));
    chk("ext", {28'h0, fs}, {28'h0, `LSA_FSC_EXT});
    apb(1'b0, `LSA_FADDR_OFS, 32'h0);
    chk("faddr", rd, 32'h30);
  endtask
  initial begin
    #200us;
    failures++;
    tally_and_finish;
  end
  bind lsa_align_unit lsa_align_unit_sva i_sva (.ref_clk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .core_req_valid, .core_req,
    .core_req_ready, .core_resp_valid, .core_resp, .mem_req_valid, .mem_req);
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, core_req_valid, exception_entry} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    stream_wdata = 32'h0;
    abort_addr = 32'hFFFF_FFF0;
    wait_n = 3'h0;
    core_req = '0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_regs;
    t_legacy;
    t_unal;
    t_abort;
    tally_and_finish;
  end
endmodule
`default_nettype wire
